// File: touch_adc_conversion_sequencer.sv
// Conversion sequencer for one preprocessed touch measurement
// Functional notes
// [R1] Step lasts 19 clocks 12-bit, 16 8-bit
// [R2] Seven conversions per command, then one result
// [R3] Filter pass takes 19 clocks after conversions
// [R4] First acquisition overlaps bus by four clocks
// [R5] Command write frame lasts 20 bus periods
// [R6] Twelve-bit read frame lasts 29 bus periods
// [R7] Eight-bit read frame lasts 20 bus periods
// [R8] Mode bit zero twelve-bit, one eight-bit
// [R9] Setup filter bit selects filter or bypass
// [R10] Read sends bits 11-4, then 3-0, zeros
// [R11] Bypass: single conversion, no filter pass
`timescale 1ns/1ps
module touch_adc_conversion_sequencer
  import touch_seq_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Command byte from the bus slave
  input wire cmd_type i_cmd,
  // Bus frame events from the bus slave
  input wire logic i_bus_start,
  input wire logic i_bus_stop,
  input wire logic i_read_frame,
  input wire logic i_byte_req,
  // Serial clock pin
  input wire logic i_scl,
  // Converter sample
  input wire logic [11:0] i_sample,
  // Status and result
  output logic o_busy,
  output logic o_sample_strobe,
  output result_type o_result,
  output logic [7:0] o_rd_byte,
  output logic o_frame_done,
  output logic o_frame_ok,
  output logic [5:0] o_frame_periods
);
  seq_state_type state_r, state_nxt;
  logic [3:0] div_r, div_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  logic [2:0] conv_r, conv_nxt;
  logic mode8_r, mode8_nxt;
  logic bypass_r, bypass_nxt;
  logic [14:0] sum_r, sum_nxt;
  logic [11:0] min_r, min_nxt;
  logic [11:0] max_r, max_nxt;
  logic [14:0] num_r, num_nxt;
  logic [2:0] rem_r, rem_nxt;
  logic [3:0] bits_r, bits_nxt;
  result_type res_r, res_nxt;
  logic strobe_r, strobe_nxt;
  logic tick;
  logic [4:0] step_len;
  logic [11:0] smp;
  logic [14:0] sum_new;
  logic [11:0] min_new;
  logic [11:0] max_new;
  logic [3:0] trial;

  // Frame period counter state
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic scl_lvl_r, scl_lvl_nxt;
  logic in_frame_r, in_frame_nxt;
  logic rd_frame_r, rd_frame_nxt;
  logic [5:0] edges_r, edges_nxt;
  logic done_r, done_nxt;
  logic ok_r, ok_nxt;
  logic [5:0] len_r, len_nxt;
  logic scl_rise;
  logic [5:0] expect_len;

  // Conversion clock made from the system clock by division
  assign tick = (div_r == CONV_CLK_DIV - 4'h1);
  assign step_len = mode8_r ? STEP_CYC_8 : STEP_CYC_12; // [R1]
  assign smp = mode8_r ? {4'h0, i_sample[11:4]} : i_sample;
  assign sum_new = sum_r + {3'h0, smp};
  assign min_new = (smp < min_r) ? smp : min_r;
  assign max_new = (smp > max_r) ? smp : max_r;
  assign trial = {rem_r, num_r[14]};

  always_comb begin
    div_nxt = tick ? 4'h0 : div_r + 4'h1;
    state_nxt = state_r;
    cyc_nxt = cyc_r;
    conv_nxt = conv_r;
    mode8_nxt = mode8_r;
    bypass_nxt = bypass_r;
    sum_nxt = sum_r;
    min_nxt = min_r;
    max_nxt = max_r;
    num_nxt = num_r;
    rem_nxt = rem_r;
    bits_nxt = bits_r;
    res_nxt = res_r;
    res_nxt.valid = 1'b0;
    strobe_nxt = 1'b0;
    // Median-average: drop extremes, divide the middle five by five, bit-serial
    if (bits_r != 4'h0) begin
      bits_nxt = bits_r - 4'h1;
      if (trial >= DIVISOR) begin
        rem_nxt = 3'(trial - DIVISOR);
        num_nxt = {num_r[13:0], 1'b1};
      end else begin
        rem_nxt = trial[2:0];
        num_nxt = {num_r[13:0], 1'b0};
      end
    end
    case (state_r)
      ST_IDLE: begin
      end
      ST_CONV: begin
        if (tick) begin
          if (cyc_r == step_len - 5'h1) begin
            strobe_nxt = 1'b1;
            cyc_nxt = 5'h0;
            conv_nxt = conv_r + 3'h1;
            sum_nxt = sum_new;
            min_nxt = min_new;
            max_nxt = max_new;
            if (bypass_r) begin
              res_nxt = '{valid: 1'b1, mode8: mode8_r, data: smp}; // [R11]
              state_nxt = ST_IDLE;
            end else if (conv_r == NUM_CONV - 3'h1) begin // [R2]
              num_nxt = sum_new - {3'h0, min_new} - {3'h0, max_new};
              rem_nxt = 3'h0;
              bits_nxt = DIV_STEPS;
              state_nxt = ST_FILT; // [R3]
            end
          end else begin
            cyc_nxt = cyc_r + 5'h1;
          end
        end
      end
      ST_FILT: begin
        if (tick) begin
          if (cyc_r == FILT_CYC - 5'h1) begin // [R3]
            res_nxt = '{valid: 1'b1, mode8: mode8_r, data: num_r[11:0]};
            state_nxt = ST_IDLE;
          end else begin
            cyc_nxt = cyc_r + 5'h1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A new measurement command overrides whatever measurement is in progress; a setup command only sets bypass
    if (i_cmd.valid) begin
      if (i_cmd.data[7:CMD_FUNC_LSB] == CMD_SETUP) begin
        bypass_nxt = i_cmd.data[CMD_FILT_BIT]; // [R9]
      end else begin
        mode8_nxt = i_cmd.data[CMD_MODE_BIT]; // [R8]
        // Drop a step end or result of the abandoned run
        strobe_nxt = 1'b0;
        res_nxt = res_r;
        res_nxt.valid = 1'b0;
        state_nxt = ST_CONV;
        cyc_nxt = OVERLAP_CYC; // [R4]
        conv_nxt = 3'h0;
        sum_nxt = 15'h0000;
        min_nxt = 12'hFFF;
        max_nxt = 12'h000;
        bits_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      div_r <= 4'h0;
      cyc_r <= 5'h00;
      conv_r <= 3'h0;
      mode8_r <= 1'b0;
      bypass_r <= FILT_BYPASS_RST;
      sum_r <= 15'h0000;
      min_r <= 12'hFFF;
      max_r <= 12'h000;
      num_r <= 15'h0000;
      rem_r <= 3'h0;
      bits_r <= 4'h0;
      res_r <= '0;
      strobe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      cyc_r <= cyc_nxt;
      conv_r <= conv_nxt;
      mode8_r <= mode8_nxt;
      bypass_r <= bypass_nxt;
      sum_r <= sum_nxt;
      min_r <= min_nxt;
      max_r <= max_nxt;
      num_r <= num_nxt;
      rem_r <= rem_nxt;
      bits_r <= bits_nxt;
      res_r <= res_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // Serial clock rise counted only once two later stages agree
  assign scl_rise = (scl_s2_r == scl_s3_r) && scl_s3_r && !scl_lvl_r;
  // Mode of the last measurement decides the expected read length
  assign expect_len = !rd_frame_r ? WR_PERIODS : // [R5]
                      (mode8_r ? RD8_PERIODS : RD12_PERIODS); // [R6] [R7]

  always_comb begin
    scl_lvl_nxt = (scl_s2_r == scl_s3_r) ? scl_s3_r : scl_lvl_r;
    in_frame_nxt = in_frame_r;
    rd_frame_nxt = rd_frame_r;
    edges_nxt = edges_r;
    done_nxt = 1'b0;
    ok_nxt = ok_r;
    len_nxt = len_r;
    if (in_frame_r && scl_rise) begin
      edges_nxt = edges_r + 6'h01;
    end
    if (i_bus_stop && in_frame_r) begin
      // START and STOP each take one period with no clock rise
      len_nxt = edges_r + EDGE_BIAS;
      ok_nxt = (edges_r + EDGE_BIAS) == expect_len;
      done_nxt = 1'b1;
      in_frame_nxt = 1'b0;
    end
    if (i_bus_start) begin
      in_frame_nxt = 1'b1;
      rd_frame_nxt = i_read_frame;
      edges_nxt = 6'h00;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      scl_lvl_r <= 1'b1;
      in_frame_r <= 1'b0;
      rd_frame_r <= 1'b0;
      edges_r <= 6'h00;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      len_r <= 6'h00;
    end else begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      scl_lvl_r <= scl_lvl_nxt;
      in_frame_r <= in_frame_nxt;
      rd_frame_r <= rd_frame_nxt;
      edges_r <= edges_nxt;
      done_r <= done_nxt;
      ok_r <= ok_nxt;
      len_r <= len_nxt;
    end
  end

  touch_result_serializer u_ser (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_rd_start(i_bus_start && i_read_frame),
    .i_byte_req(i_byte_req),
    .i_result(res_r.data),
    .i_mode8(res_r.mode8),
    .o_byte(o_rd_byte)
  );

  assign o_busy = (state_r != ST_IDLE);
  assign o_sample_strobe = strobe_r;
  assign o_result = res_r;
  assign o_frame_done = done_r;
  assign o_frame_ok = ok_r;
  assign o_frame_periods = len_r;
endmodule

// File: touch_seq_pkg.sv
// Shared constants and carrier types for the touch conversion sequencer
package touch_seq_pkg;
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned CONV_CLK_PERIOD_NS = 250;
  localparam int unsigned CONV_CLK_DIV_INT = CONV_CLK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [3:0] CONV_CLK_DIV = 4'(CONV_CLK_DIV_INT);
  localparam logic [4:0] STEP_CYC_12 = 5'h13;
  localparam logic [4:0] STEP_CYC_8 = 5'h10;
  localparam logic [4:0] FILT_CYC = 5'h13;
  localparam logic [4:0] OVERLAP_CYC = 5'h04;
  localparam logic [2:0] NUM_CONV = 3'h7;
  localparam logic [5:0] WR_PERIODS = 6'h14;
  localparam logic [5:0] RD12_PERIODS = 6'h1D;
  localparam logic [5:0] RD8_PERIODS = 6'h14;
  localparam logic [5:0] EDGE_BIAS = 6'h02;
  localparam logic [3:0] CMD_SETUP = 4'hB;
  localparam int unsigned CMD_FUNC_LSB = 4;
  localparam int unsigned CMD_MODE_BIT = 1;
  localparam int unsigned CMD_FILT_BIT = 1;
  localparam logic FILT_BYPASS_RST = 1'b0;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] DIVISOR = 4'h5;
  localparam logic [3:0] DIV_STEPS = 4'hF;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cmd_type;

  typedef struct packed {
    logic valid;
    logic mode8;
    logic [11:0] data;
  } result_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_FILT = 3'b100
  } seq_state_type;
endpackage

// File: touch_result_serializer.sv
// Result byte selector for the read transaction
`timescale 1ns/1ps
module touch_result_serializer
  import touch_seq_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Read frame control
  input wire logic i_rd_start,
  input wire logic i_byte_req,
  // Result
  input wire logic [11:0] i_result,
  input wire logic i_mode8,
  // Byte to shift out
  output logic [7:0] o_byte
);
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;

  function automatic logic [7:0] pick(input logic [1:0] idx, input logic m8,
                                      input logic [11:0] r);
    logic [7:0] b;
    b = FILL_BYTE;
    if (idx == 2'h0) begin
      b = m8 ? r[7:0] : r[11:4]; // [R10]
    end else if (idx == 2'h1 && !m8) begin
      b = {r[3:0], 4'h0}; // [R10]
    end
    return b;
  endfunction

  always_comb begin
    idx_nxt = idx_r;
    byte_nxt = byte_r;
    if (i_rd_start) begin
      idx_nxt = 2'h0;
      byte_nxt = pick(2'h0, i_mode8, i_result);
    end else if (i_byte_req) begin
      // Saturate so an acknowledged extra byte keeps reading fill
      idx_nxt = (idx_r == 2'h3) ? idx_r : idx_r + 2'h1;
      byte_nxt = pick(idx_nxt, i_mode8, i_result);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      idx_r <= 2'h0;
      byte_r <= 8'h00;
    end else begin
      idx_r <= idx_nxt;
      byte_r <= byte_nxt;
    end
  end

  assign o_byte = byte_r;
endmodule

// File: touch_seq_monitor.sv
// Checker for the touch conversion sequencer
`timescale 1ns/1ps
module touch_seq_monitor
  import touch_seq_pkg::*;
(
  // Inputs
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire cmd_type i_cmd,
  input wire logic i_bus_start,
  input wire logic i_bus_stop,
  input wire logic i_read_frame,
  // Outputs
  input wire logic o_busy,
  input wire logic o_sample_strobe,
  input wire result_type o_result,
  input wire logic [7:0] o_rd_byte,
  input wire logic o_frame_done,
  input wire logic o_frame_ok,
  input wire logic [5:0] o_frame_periods
);
  logic meas, m8_r, m8_nxt, byp_r, byp_nxt, op_r, op_nxt, rd_r, rd_nxt;
  logic [2:0] sc_r, sc_nxt;
  logic [11:0] gap_r, gap_nxt, lat_r, lat_nxt, ex;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  assign meas = i_cmd.valid && i_cmd.data[7:4] != CMD_SETUP;
  // Tick phase is free, so latency is only known to one tick
  assign ex = 12'h00C * (byp_r ? (m8_r ? 12'h00C : 12'h00F) : (m8_r ? 12'h07F : 12'h094));
  always_comb begin
    m8_nxt = meas ? i_cmd.data[CMD_MODE_BIT] : m8_r;
    byp_nxt = i_cmd.valid && !meas ? i_cmd.data[CMD_FILT_BIT] : byp_r;
    op_nxt = i_bus_start | (op_r & ~i_bus_stop);
    rd_nxt = i_bus_start ? i_read_frame : rd_r;
    sc_nxt = meas ? 3'h0 : sc_r + 3'(o_sample_strobe);
    gap_nxt = meas || o_sample_strobe ? 12'h000 : gap_r + 12'h001;
    lat_nxt = meas ? 12'h000 : lat_r + 12'h001;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      {m8_r, byp_r, op_r, rd_r, sc_r, gap_r, lat_r} <= '0;
    end else begin
      {m8_r, byp_r, op_r, rd_r} <= {m8_nxt, byp_nxt, op_nxt, rd_nxt};
      {sc_r, gap_r, lat_r} <= {sc_nxt, gap_nxt, lat_nxt};
    end
  end
  a_busy_start: assert property (meas |=> o_busy)
    else $error("busy missing");
  a_result_idle: assert property (o_result.valid |-> !o_busy)
    else $error("busy at result");
  a_step_len: assert property (o_sample_strobe && sc_r != 3'h0 |->
    gap_r == (m8_r ? 12'h0BF : 12'h0E3))
    else $error("step length");
  a_strobe_cnt: assert property (o_result.valid |->
    sc_r + 3'(o_sample_strobe) == (byp_r ? 3'h1 : 3'h7))
    else $error("step count");
  a_cmd_latency: assert property (o_result.valid |->
    lat_r inside {[ex - 12'h00D : ex + 12'h00C]})
    else $error("latency");
  a_frame_done: assert property (i_bus_stop && op_r |=> o_frame_done)
    else $error("frame end");
  a_frame_ok: assert property (o_frame_done |-> o_frame_ok ==
    (o_frame_periods == (rd_r && !m8_r ? 6'h1D : 6'h14)))
    else $error("frame check");
  a_byte_first: assert property (i_bus_start && i_read_frame |=> o_rd_byte ==
    (o_result.mode8 ? o_result.data[7:0] : o_result.data[11:4]))
    else $error("first byte");
endmodule
bind touch_adc_conversion_sequencer touch_seq_monitor touch_seq_monitor_inst (.*);

// File: host_model.sv
// Bus master model producing frame events
`timescale 1ns/1ps
module host_model
  import touch_seq_pkg::*;
(
  // Clock and read data
  input wire logic i_mclk,
  input wire logic [7:0] i_byte,
  // Frame events
  output cmd_type o_cmd,
  output logic o_start,
  output logic o_stop,
  output logic o_rd,
  output logic o_req,
  output logic o_scl
);
  logic [7:0] got[$];
  initial begin
    {o_cmd, o_start, o_stop, o_rd, o_req} = '0;
    o_scl = 1'b1;
  end
  task automatic xfer(input logic rd, input logic [7:0] c, input int np, input int nr,
                      input int w);
    @(posedge i_mclk);
    o_rd <= rd;
    o_start <= 1'b1;
    @(posedge i_mclk);
    o_start <= 1'b0;
    @(posedge i_mclk);
    if (rd) got.push_back(i_byte);
    // START and STOP take a period each
    for (int i = 0; i < np - 2; i++) begin
      o_scl <= 1'b0;
      repeat (w) @(posedge i_mclk);
      o_scl <= 1'b1;
      repeat (w) @(posedge i_mclk);
    end
    if (!rd) begin
      o_cmd <= {1'b1, c};
      @(posedge i_mclk);
      o_cmd.valid <= 1'b0;
    end
    repeat (nr) begin
      o_req <= 1'b1;
      @(posedge i_mclk);
      o_req <= 1'b0;
      @(posedge i_mclk);
      got.push_back(i_byte);
    end
    // Lets the synchronised last rise land
    repeat (4) @(posedge i_mclk);
    o_stop <= 1'b1;
    @(posedge i_mclk);
    o_stop <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the touch conversion sequencer
`timescale 1ns/1ps
module testbench;
  import touch_seq_pkg::*;
  logic i_mclk, i_reset, o_busy, o_sample_strobe, o_frame_done, o_frame_ok;
  logic i_bus_start, i_bus_stop, i_read_frame, i_byte_req, i_scl;
  cmd_type i_cmd;
  result_type o_result;
  logic [11:0] i_sample = 12'h5A3;
  logic [7:0] o_rd_byte;
  logic [5:0] o_frame_periods;
  logic [31:0] seed = 32'h86E1A966;
  logic [11:0] smp[$];
  logic m8 = 1'b0;
  logic byp = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  touch_adc_conversion_sequencer touch_adc_conversion_sequencer_inst (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_cmd(i_cmd), .i_bus_start(i_bus_start),
    .i_bus_stop(i_bus_stop), .i_read_frame(i_read_frame), .i_byte_req(i_byte_req),
    .i_scl(i_scl), .i_sample(i_sample), .o_busy(o_busy),
    .o_sample_strobe(o_sample_strobe), .o_result(o_result), .o_rd_byte(o_rd_byte),
    .o_frame_done(o_frame_done), .o_frame_ok(o_frame_ok),
    .o_frame_periods(o_frame_periods));
  host_model host_model_inst (.i_mclk(i_mclk), .i_byte(o_rd_byte), .o_cmd(i_cmd),
    .o_start(i_bus_start), .o_stop(i_bus_stop), .o_rd(i_read_frame),
    .o_req(i_byte_req), .o_scl(i_scl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] expect_val();
    int s, mn, mx, v;
    s = 0;
    mn = 4096;
    mx = -1;
    foreach (smp[i]) begin
      v = m8 ? int'(smp[i][11:4]) : int'(smp[i]);
      s += v;
      mn = v < mn ? v : mn;
      mx = v > mx ? v : mx;
    end
    return byp ? 12'(s) : 12'((s - mn - mx) / 5);
  endfunction
  task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic frame(input logic rd, input logic [7:0] c, input int np, input int nr);
    host_model_inst.got.delete();
    host_model_inst.xfer(rd, c, np, nr, 2 + rnd() % 4);
    chk("periods", 12'(o_frame_periods), 12'(np));
    chk("frame_ok", 12'(o_frame_ok), 12'(np == (rd && !m8 ? 29 : 20)));
  endtask
  task automatic run(input logic [7:0] c, input int nr);
    logic [11:0] e;
    m8 = c[1];
    frame(1'b0, c, 20, 0);
    chk("busy", 12'(o_busy), 12'h001);
    repeat (3000) if (!o_result.valid) @(posedge i_mclk);
    chk("valid", 12'(o_result.valid), 12'h001);
    chk("idle", 12'(o_busy), 12'h000);
    // In bypass the only sample is queued at this same edge, so wait half a clock
    @(negedge i_mclk);
    e = expect_val();
    chk("result", o_result.data, e);
    chk("mode8", 12'(o_result.mode8), 12'(m8));
    frame(1'b1, 8'h00, m8 ? 20 : 29, nr);
    chk("byte0", 12'(host_model_inst.got[0]), 12'(m8 ? e[7:0] : e[11:4]));
    if (!m8) chk("byte1", 12'(host_model_inst.got[1]), {4'h0, e[3:0], 4'h0});
    if (nr > (m8 ? 0 : 1)) chk("fill", 12'(host_model_inst.got[nr]), 12'h0FF);
  endtask
  // Sample moves right after each step end, so a late pick is caught
  // A strobe at the command edge belongs to the abandoned run
  always @(posedge i_mclk) begin
    if (i_cmd.valid) smp.delete();
    else if (o_sample_strobe) smp.push_back(i_sample);
    if (o_sample_strobe) i_sample <= 12'(rnd());
  end
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
  initial begin
    i_reset = 1'b1;
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      logic [7:0] c;
      c = 8'(rnd());
      if (c[7:4] == CMD_SETUP) c[7:4] = 4'hC;
      c[1] = i[0];
      byp = i[1];
      frame(1'b0, {CMD_SETUP, 2'b00, byp, 1'b0}, 20, 0);
      run(c, (i[0] ? 0 : 1) + i[2]);
    end
    byp = 1'b0;
    frame(1'b0, {CMD_SETUP, 4'h0}, 20, 0);
    frame(1'b0, 8'hC2, 20, 0);
    repeat (400) @(posedge i_mclk);
    run(8'hD0, 1);
    frame(1'b1, 8'h00, 25, 0);
    test_done();
  end
endmodule
